// ### bench/ir_keypad_model.sv
/*
 Keypad matrix and strap wiring model facing the transmitter's scan pins.
 Assumes the bench chooses the held key and the strapped drive lines.
*/
`timescale 1ns/10ps
module ir_keypad_model (
   input wire logic clock,
   input wire logic [6:0] drive_oe,
   input wire logic pullup_en,
   input wire logic pulldown_en,
   input wire logic key_on,
   input wire logic [2:0] key_drive,
   input wire logic [2:0] key_row,
   input wire logic [6:0] strap_mask,
   output logic [6:0] sense_n,
   output logic strap
);
   logic float_ff = 1'b0;

   // A strap pin with neither load switched on and no strapped drive line enabled shows a changing level, never a held one.
   always @(posedge clock) begin
      float_ff <= ~float_ff;
   end

   always_comb begin
      sense_n = 7'h7f;
      if (key_on && drive_oe[key_drive]) begin
         if (key_row == 3'h7) begin
            sense_n[5] = 1'b0;
            sense_n[6] = 1'b0;
         end else begin
            sense_n[key_row] = 1'b0;
         end
      end
      if (pulldown_en) begin
         strap = 1'b0;
      end else if ((strap_mask & drive_oe) != 7'h00) begin
         strap = 1'b0;
      end else if (pullup_en) begin
         strap = 1'b1;
      end else begin
         strap = float_ff;
      end
   end
endmodule : ir_keypad_model

// ### bench/ir_remote_pulse_distance_transmitter_test.sv
/*
 Self-checking bench: presses keys with various straps and decodes the pulse train.
 Assumes the keypad model and shortened oscillator, unit and word counts.
*/
`timescale 1ns/10ps
`define check(name, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected %s exp %0h got %0h", name, exp, got); end end
module ir_remote_pulse_distance_transmitter_test;
   localparam int OC = 4;
   localparam int UNIT = 5;
   localparam int WS = 240;
   localparam int WL = 260;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic key_on = 1'b0;
   logic [2:0] key_drive = 3'h0;
   logic [2:0] key_row = 3'h0;
   logic [6:0] strap_mask = 7'h00;
   logic [6:0] sense_n;
   logic [6:0] drive_oe;
   logic [6:0] drive_out;
   logic strap, pullup_en, pulldown_en, standby, ir;
   logic ir_prev = 1'b0;
   logic [31:0] rnd = 32'h000106d2;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   int tog = 0;
   int starts[$], edges[$], highs[$], exp_bits[$];
   int straps[18] = '{'h00, 'h01, 'h02, 'h04, 'h08, 'h10, 'h20, 'h05, 'h09, 'h11, 'h21, 'h0a, 'h14, 'h24,
      'h18, 'h28, 'h40, 'h49};

   always #10 clock = ~clock;

   ir_remote_pulse_distance_transmitter #(.OSC_CYC(OC), .UNIT_OSC(UNIT), .WORD_SHORT_OSC(WS),
      .WORD_LONG_OSC(WL)) dut_u (
      .clock(clock), .nrst(nrst), .clk_en(clk_en), .scan_sense_lines_n(sense_n),
      .address_mode_strap_input(strap), .scan_drive_lines_out(drive_out), .scan_drive_lines_oe(drive_oe),
      .strap_pullup_en(pullup_en), .strap_pulldown_en(pulldown_en), .standby(standby),
      .infrared_pulse_output(ir));

   ir_keypad_model key_u (
      .clock(clock), .drive_oe(drive_oe), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
      .key_on(key_on), .key_drive(key_drive), .key_row(key_row), .strap_mask(strap_mask),
      .sense_n(sense_n), .strap(strap));

   // ****************************************
   // Receiver: records pulse starts, carrier edges and high time
   // ****************************************
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (ir === 1'b1 && ir_prev !== 1'b1) begin
         if (starts.size() == 0 || cyc - starts[starts.size() - 1] >= 9 * OC) begin
            starts.push_back(cyc);
            edges.push_back(0);
            highs.push_back(0);
         end
         edges[edges.size() - 1]++;
      end
      if (ir === 1'b1 && highs.size() > 0) begin
         highs[highs.size() - 1]++;
      end
      ir_prev = ir;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction : lfsr

   // Bit 4 of the result marks a long word.
   function automatic int grp_of(input logic [6:0] m);
      int a, b, n;
      a = -1;
      b = 0;
      n = 0;
      for (int k = 0; k < 6; k++) begin
         if (m[k]) begin
            if (a < 0) begin
               a = k;
            end
            b = k;
            n++;
         end
      end
      if (n == 0) begin
         return 7;
      end
      if (n == 1) begin
         return a;
      end
      return 16 | ((b & 1) << 3) | ((b >= 4) << 2) | (a & 3);
   endfunction : grp_of

   task automatic print_verdict();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic wait_pulses(input int n);
      for (int i = 0; i < 4 * WL * OC && starts.size() < n; i++) begin
         @(negedge clock);
      end
      if (starts.size() < n) begin
         num_errors++;
         $display("unexpected pulse count exp %0d got %0d", n, starts.size());
         print_verdict();
      end
   endtask : wait_pulses

   task automatic check_word(input int base, input int g, input int code, input logic modul);
      int i;
      int sp;
      exp_bits = {tog & 1, (tog >> 1) & 1};
      for (i = (g > 15) ? 3 : 2; i >= 0; i--) begin
         exp_bits.push_back((g >> i) & 1);
      end
      for (i = 5; i >= 0; i--) begin
         exp_bits.push_back((code >> i) & 1);
      end
      wait_pulses(base + exp_bits.size() + 1);
      for (i = 0; i < exp_bits.size(); i++) begin
         sp = starts[base + i + 1] - starts[base + i];
         `check("bit spacing", (exp_bits[i] ? 3 : 2) * UNIT * OC, sp)
      end
      `check("carrier edges", modul ? 8 : 1, edges[base])
      `check("pulse high time", 4 * OC, highs[base])
   endtask : check_word

   initial begin
      int g, n;
      logic modul;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      repeat (3) @(negedge clock);
      `check("standby", 1'b1, standby)
      `check("pull-down", 1'b1, pulldown_en)
      `check("pull-up", 1'b0, pullup_en)
      `check("drive enables", 7'h7f, drive_oe)
      `check("drive value", 7'h00, drive_out)
      `check("ir idle", 1'b0, ir)
      strap_mask = 7'h3f;
      repeat (100) @(negedge clock);
      `check("standby after strap", 1'b1, standby)
      `check("pulses after strap", 0, starts.size())
      for (int p = 0; p < 18; p++) begin
         rnd = lfsr(rnd);
         key_drive = 3'(rnd % 7);
         key_row = 3'((rnd >> 8) % 8);
         strap_mask = 7'(straps[p]);
         g = grp_of(strap_mask);
         n = (g > 15) ? 12 : 11;
         modul = strap_mask[6];
         starts.delete();
         edges.delete();
         highs.delete();
         if (p == 5) begin
            key_row = 3'h7;
         end
         // A press while the clock enable is low must not be seen until the enable returns.
         clk_en = 1'b0;
         key_on = 1'b1;
         repeat (int'(rnd[19:16]) + 2) @(negedge clock);
         `check("frozen standby", 1'b1, standby)
         clk_en = 1'b1;
         tog++;
         wait_pulses(1);
         `check("pull-up active", 1'b1, pullup_en)
         `check("pull-down active", 1'b0, pulldown_en)
         if (p % 3 == 1) begin
            key_on = 1'b0;
         end
         if (p % 3 == 2) begin
            strap_mask = ~strap_mask;
         end
         check_word(0, g, {key_row, key_drive}, modul);
         if (p % 3 == 2) begin
            check_word(n + 1, g, {key_row, key_drive}, modul);
            `check("word period", ((g > 15) ? WL : WS) * OC, starts[n + 1] - starts[0])
         end
         key_on = 1'b0;
         for (int i = 0; i < 3 * WL * OC && standby !== 1'b1; i++) begin
            @(negedge clock);
         end
         `check("back to standby", 1'b1, standby)
         `check("pull-down again", 1'b1, pulldown_en)
         if (standby !== 1'b1) begin
            print_verdict();
         end
         repeat (4) @(negedge clock);
      end
      print_verdict();
   end
endmodule : ir_remote_pulse_distance_transmitter_test

// ### rtl/ir_remote_pulse_distance_transmitter.sv
/*
 Key-matrix scanner and pulse-distance infrared word generator.
 Assumes sense and strap pins have external-style pull-ups modelled outside and
 arrive asynchronously; drive lines are open-drain with the enable high while pulling low.
*/
`timescale 1ns/10ps
module ir_remote_pulse_distance_transmitter #(
   parameter int OSC_CYC = ir_tx_pkg::OSC_CYC,
   parameter int UNIT_OSC = ir_tx_pkg::UNIT_OSC,
   parameter int WORD_SHORT_OSC = ir_tx_pkg::WORD_SHORT_OSC,
   parameter int WORD_LONG_OSC = ir_tx_pkg::WORD_LONG_OSC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [6:0] scan_sense_lines_n,
   input wire logic address_mode_strap_input,
   output logic [6:0] scan_drive_lines_out,
   output logic [6:0] scan_drive_lines_oe,
   output logic strap_pullup_en,
   output logic strap_pulldown_en,
   output logic standby,
   output logic infrared_pulse_output
);

   // ****************************************
   // Decoding helpers
   // ****************************************

   // Returns {long, top, bit two, bit one, bit zero} of the group address.
   function automatic logic [4:0] addr_decode(input logic [6:0] hits);
      logic [2:0] lo;
      logic [2:0] hi;
      logic [2:0] cnt;
      lo = 3'h0;
      hi = 3'h0;
      cnt = 3'h0;
      for (int i = ir_tx_pkg::MODE_LINE - 1; i >= 0; i--) begin
         if (hits[i]) begin
            lo = 3'(i);
            cnt = cnt + 3'h1;
         end
      end
      for (int i = 0; i < ir_tx_pkg::MODE_LINE; i++) begin
         if (hits[i]) begin
            hi = 3'(i);
         end
      end
      if (cnt == 3'h0) begin
         addr_decode = {2'b00, ir_tx_pkg::GRP_NONE};
      end else if (cnt == 3'h1) begin
         addr_decode = {2'b00, lo};
      end else begin
         addr_decode = {1'b1, hi[0], hi >= ir_tx_pkg::HIGH_LINE, lo[1:0]};
      end
   endfunction : addr_decode

   // Key code from drive index and sampled sense lines.
   function automatic logic [5:0] key_code(input logic [2:0] drv, input logic [6:0] sen_n);
      logic [2:0] row;
      row = 3'h0;
      for (int j = ir_tx_pkg::NUM_LINES - 1; j >= 0; j--) begin
         if (!sen_n[j]) begin
            row = 3'(j);
         end
      end
      if (!sen_n[ir_tx_pkg::TRIPLE_A] && !sen_n[ir_tx_pkg::TRIPLE_B]) begin
         row = ir_tx_pkg::TRIPLE_ROW;
      end
      key_code = {row, drv};
   endfunction : key_code

   // ****************************************
   // State and next-state logic
   // ****************************************

   localparam logic [7:0] OSC_LAST = 8'(OSC_CYC - 1);
   localparam logic [7:0] OSC_HALF = 8'(OSC_CYC / 2);
   localparam logic [15:0] GAP_ZERO = 16'(ir_tx_pkg::ZERO_UNITS * UNIT_OSC - 1);
   localparam logic [15:0] GAP_ONE = 16'(ir_tx_pkg::ONE_UNITS * UNIT_OSC - 1);
   localparam logic [15:0] WORD_SHORT_LAST = 16'(WORD_SHORT_OSC - 1);
   localparam logic [15:0] WORD_LONG_LAST = 16'(WORD_LONG_OSC - 1);

   ir_tx_pkg::core_t core_ff;
   ir_tx_pkg::core_t nxt_core;
   logic tick;
   logic carrier;
   logic pulse_on;
   logic pulse_start;
   logic [6:0] hits_now;
   logic key_now;
   logic [5:0] code_now;
   logic [4:0] adr_now;
   logic [15:0] gap_target;

   assign tick = core_ff.osc_cnt == OSC_LAST;
   assign carrier = core_ff.osc_cnt < OSC_HALF;
   assign pulse_on = core_ff.pulse_cnt != 4'h0;
   assign gap_target = core_ff.word_sh[11] ? GAP_ONE : GAP_ZERO;

   always_comb begin
      nxt_core = core_ff;
      pulse_start = 1'b0;
      hits_now = core_ff.hits;
      key_now = core_ff.key_seen;
      code_now = core_ff.code;
      adr_now = addr_decode(core_ff.hits);
      nxt_core.sen_m = scan_sense_lines_n;
      nxt_core.sen_q = core_ff.sen_m;
      nxt_core.adr_m = address_mode_strap_input;
      nxt_core.adr_q = core_ff.adr_m;
      nxt_core.osc_cnt = tick ? 8'h0 : core_ff.osc_cnt + 8'h1;
      if (tick) begin
         if (pulse_on) begin
            nxt_core.pulse_cnt = core_ff.pulse_cnt - 4'h1;
         end
         nxt_core.word_cnt = core_ff.word_cnt + 16'h1;
         nxt_core.gap_cnt = core_ff.gap_cnt + 16'h1;
      end
      unique case (core_ff.st)
         ir_tx_pkg::ST_STANDBY: begin
            nxt_core.drive_oe = '1;
            if (!(&core_ff.sen_q)) begin
               nxt_core.st = ir_tx_pkg::ST_SCAN;
               nxt_core.first = 1'b1;
               nxt_core.toggle = core_ff.toggle + 2'h1;
               nxt_core.idx = 3'h0;
               nxt_core.settle = 3'h0;
               nxt_core.hits = '0;
               nxt_core.key_seen = 1'b0;
               nxt_core.word_cnt = 16'h0;
               nxt_core.drive_oe = 7'h1;
            end
         end
         ir_tx_pkg::ST_SCAN: begin
            if (tick && core_ff.settle == ir_tx_pkg::SETTLE_OSC) begin
               hits_now[core_ff.idx] = !core_ff.adr_q;
               if (!core_ff.key_seen && !(&core_ff.sen_q)) begin
                  key_now = 1'b1;
                  code_now = key_code(core_ff.idx, core_ff.sen_q);
               end
               nxt_core.hits = hits_now;
               nxt_core.key_seen = key_now;
               nxt_core.code = code_now;
               nxt_core.settle = 3'h0;
               if (core_ff.idx == ir_tx_pkg::LAST_LINE) begin
                  nxt_core.drive_oe = '0;
                  nxt_core.first = 1'b0;
                  if (core_ff.first) begin
                     adr_now = addr_decode(hits_now);
                     nxt_core.grp = adr_now[3:0];
                     nxt_core.long_adr = adr_now[4];
                     nxt_core.modulated = hits_now[ir_tx_pkg::MODE_LINE];
                  end else begin
                     adr_now = {core_ff.long_adr, core_ff.grp};
                  end
                  if (key_now) begin
                     nxt_core.st = ir_tx_pkg::ST_SEND;
                     pulse_start = 1'b1;
                     if (adr_now[4]) begin
                        nxt_core.word_sh = {core_ff.toggle[0], core_ff.toggle[1], adr_now[3:0], code_now};
                        nxt_core.bits_left = ir_tx_pkg::BITS_LONG;
                     end else begin
                        nxt_core.word_sh = {core_ff.toggle[0], core_ff.toggle[1], adr_now[2:0], code_now, 1'b0};
                        nxt_core.bits_left = ir_tx_pkg::BITS_SHORT;
                     end
                  end else begin
                     nxt_core.st = ir_tx_pkg::ST_STANDBY;
                     nxt_core.drive_oe = '1;
                  end
               end else begin
                  nxt_core.idx = core_ff.idx + 3'h1;
                  nxt_core.drive_oe = core_ff.drive_oe << 1;
               end
            end else if (tick) begin
               nxt_core.settle = core_ff.settle + 3'h1;
            end
         end
         ir_tx_pkg::ST_SEND: begin
            if (tick && core_ff.gap_cnt == gap_target) begin
               pulse_start = 1'b1;
               nxt_core.word_sh = core_ff.word_sh << 1;
               nxt_core.bits_left = core_ff.bits_left - 4'h1;
               if (core_ff.bits_left == 4'h1) begin
                  nxt_core.st = ir_tx_pkg::ST_GAP;
               end
            end
         end
         ir_tx_pkg::ST_GAP: begin
            if (tick && core_ff.word_cnt == (core_ff.long_adr ? WORD_LONG_LAST : WORD_SHORT_LAST)) begin
               nxt_core.st = ir_tx_pkg::ST_SCAN;
               nxt_core.idx = 3'h0;
               nxt_core.settle = 3'h0;
               nxt_core.key_seen = 1'b0;
               nxt_core.word_cnt = 16'h0;
               nxt_core.drive_oe = 7'h1;
            end
         end
      endcase
      if (pulse_start) begin
         nxt_core.gap_cnt = 16'h0;
         nxt_core.pulse_cnt = nxt_core.modulated ? ir_tx_pkg::BURST_OSC : ir_tx_pkg::FLASH_OSC;
      end
      nxt_core.ir = pulse_on && (!core_ff.modulated || carrier);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         // Sense synchronisers start at the idle high level so that reset never looks like a key press.
         core_ff <= '0;
         core_ff.sen_m <= '1;
         core_ff.sen_q <= '1;
         core_ff.drive_oe <= '1;
      end else if (clk_en) begin
         core_ff <= nxt_core;
      end
   end

   assign scan_drive_lines_out = '0;
   assign scan_drive_lines_oe = core_ff.drive_oe;
   assign standby = core_ff.st == ir_tx_pkg::ST_STANDBY;
   assign strap_pulldown_en = standby;
   assign strap_pullup_en = !standby;
   assign infrared_pulse_output = core_ff.ir;

   // ****************************************
   // Checks
   // ****************************************

   sequence s_wake;
      standby && clk_en && !(&core_ff.sen_q);
   endsequence

   sequence s_enter_scan;
      core_ff.st == ir_tx_pkg::ST_SCAN && core_ff.first && strap_pullup_en && !strap_pulldown_en;
   endsequence

   property p_standby_pins;
      @(posedge clock) disable iff (!nrst)
      standby |-> (&scan_drive_lines_oe) && strap_pulldown_en && !strap_pullup_en && !infrared_pulse_output;
   endproperty
   a_standby_pins: assert property (p_standby_pins) else $error("standby pin state wrong");

   property p_wake;
      @(posedge clock) disable iff (!nrst)
      s_wake |=> s_enter_scan;
   endproperty
   a_wake: assert property (p_wake) else $error("key press did not wake");

   property p_no_strap_start;
      @(posedge clock) disable iff (!nrst)
      standby && (&core_ff.sen_q) |=> standby;
   endproperty
   a_no_strap_start: assert property (p_no_strap_start) else $error("left standby without key");

   property p_scan_onehot;
      @(posedge clock) disable iff (!nrst)
      core_ff.st == ir_tx_pkg::ST_SCAN |-> $onehot(scan_drive_lines_oe);
   endproperty
   a_scan_onehot: assert property (p_scan_onehot) else $error("scan drives not one-hot");

   property p_addr_latch;
      @(posedge clock) disable iff (!nrst)
      $fell(core_ff.first) |-> {core_ff.long_adr, core_ff.grp} == addr_decode(core_ff.hits)
         && core_ff.modulated == core_ff.hits[ir_tx_pkg::MODE_LINE];
   endproperty
   a_addr_latch: assert property (p_addr_latch) else $error("group address decode wrong");

   property p_addr_hold;
      @(posedge clock) disable iff (!nrst)
      !core_ff.first && !standby && !$past(core_ff.first) |-> $stable(core_ff.grp) && $stable(core_ff.modulated);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address changed after first scan");

   property p_toggle;
      @(posedge clock) disable iff (!nrst)
      s_wake |=> core_ff.toggle == $past(core_ff.toggle) + 2'h1;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not change on new press");

   property p_ir_pulse;
      @(posedge clock) disable iff (!nrst)
      infrared_pulse_output |-> $past(pulse_on) && (!$past(core_ff.modulated) || $past(carrier));
   endproperty
   a_ir_pulse: assert property (p_ir_pulse) else $error("output high outside pulse");

   property p_spacing;
      @(posedge clock) disable iff (!nrst)
      pulse_start && core_ff.st == ir_tx_pkg::ST_SEND |-> core_ff.gap_cnt == GAP_ZERO || core_ff.gap_cnt == GAP_ONE;
   endproperty
   a_spacing: assert property (p_spacing) else $error("pulse spacing not two or three units");

   property p_word_len;
      @(posedge clock) disable iff (!nrst)
      core_ff.st == ir_tx_pkg::ST_SEND |-> core_ff.word_cnt <= WORD_LONG_LAST;
   endproperty
   a_word_len: assert property (p_word_len) else $error("word overran its length");

endmodule : ir_remote_pulse_distance_transmitter

// ### rtl/ir_tx_pkg.sv
/*
 Constants, types and state record for the pulse-distance infrared transmitter.
 Assumes a 50 MHz system clock from which the oscillator period is derived.
*/
// How it works
// - Up to 20 group addresses, each with 56 key codes.
// - Keyboard scanned as seven drive lines by seven sense lines.
// - Drive lines are open-drain and all pull low during standby.
// - A sense line pulled low wakes the block and starts sending.
// - Group address comes from one or two lines strapped to the strap input.
// - Seventh drive line strapped selects carrier mode, else single flashes.
// - No strap gives 111; single line k gives k in binary.
// - In standby only the strap pull-down is on.
// - On a press the pull-down goes off, pull-up on, then straps are sensed.
// - Address sampled in first scan only; key code on every scan.
// - A strap change alone never starts a transmission.
// - Two toggle bits open each word and change on each new press.
// - Toggles, group bits, then six code bits; top group bit only when long.
// - Infrared output is high only while a pulse is active.
// - Timing counts oscillator periods; bits set by leading-edge spacing.
// - Carrier runs at the oscillator rate, nominally 455 kHz.
// - Code low bits are drive index, high bits sense index, triple gives 56+.
// - Unit is 1152 periods; zero spans two units, one spans three.
// - Word repeats every 55296 periods, or 59904 for long addresses.
package ir_tx_pkg;
   localparam int CLK_FREQ_HZ = 50000000;
   localparam int OSC_FREQ_HZ = 455000;
   localparam int OSC_CYC = (CLK_FREQ_HZ + OSC_FREQ_HZ / 2) / OSC_FREQ_HZ;
   localparam int NUM_LINES = 7;
   localparam int UNIT_OSC = 1152;
   localparam int ZERO_UNITS = 2;
   localparam int ONE_UNITS = 3;
   localparam int WORD_SHORT_OSC = 55296;
   localparam int WORD_LONG_OSC = 59904;
   localparam logic [3:0] FLASH_OSC = 4'h4;
   localparam logic [3:0] BURST_OSC = 4'h8;
   localparam logic [2:0] SETTLE_OSC = 3'h3;
   localparam logic [2:0] LAST_LINE = 3'h6;
   localparam logic [2:0] TRIPLE_ROW = 3'h7;
   localparam int TRIPLE_A = 5;
   localparam int TRIPLE_B = 6;
   localparam int MODE_LINE = 6;
   localparam logic [2:0] GRP_NONE = 3'h7;
   localparam logic [2:0] HIGH_LINE = 3'h4;
   localparam logic [3:0] BITS_SHORT = 4'hb;
   localparam logic [3:0] BITS_LONG = 4'hc;

   typedef enum logic [1:0] {ST_STANDBY, ST_SCAN, ST_SEND, ST_GAP} state_t;

   typedef struct packed {
      state_t st;
      logic [6:0] sen_m;
      logic [6:0] sen_q;
      logic adr_m;
      logic adr_q;
      logic [7:0] osc_cnt;
      logic [2:0] idx;
      logic [2:0] settle;
      logic first;
      logic [6:0] hits;
      logic key_seen;
      logic [5:0] code;
      logic [3:0] grp;
      logic long_adr;
      logic modulated;
      logic [1:0] toggle;
      logic [11:0] word_sh;
      logic [3:0] bits_left;
      logic [15:0] word_cnt;
      logic [15:0] gap_cnt;
      logic [3:0] pulse_cnt;
      logic [6:0] drive_oe;
      logic ir;
   } core_t;
endpackage : ir_tx_pkg
